// ===== hdl/fscs_pkg.sv
// constants for the flash security, configuration and status block
package fscs_pkg;
  // security register bit positions
  localparam int SEC_PMODE_BIT  = 7;
  localparam int SEC_EFAIL_BIT  = 6;
  localparam int SEC_PFAIL_BIT  = 5;
  localparam int SEC_RSVD_BIT   = 4;
  localparam int SEC_ESUSP_BIT  = 3;
  localparam int SEC_PSUSP_BIT  = 2;
  localparam int SEC_LOCK_BIT   = 1;
  localparam int SEC_FACT_BIT   = 0;
  // configuration byte layout
  localparam int CFG_DC_LSB     = 6;
  localparam int CFG_DS_LSB     = 0;
  // reset values
  localparam logic [1:0] DC_DEFAULT = 2'h0;
  localparam logic [2:0] DS_DEFAULT = 3'h7;
  // dummy counts, one per code 00/01/10/11
  localparam logic [3:0] DUM_FAST [4] = '{4'h8, 4'h6, 4'h8, 4'hA};
  localparam logic [3:0] DUM_DIO  [4] = '{4'h4, 4'h6, 4'h8, 4'hA};
  localparam logic [3:0] DUM_QIO  [4] = '{4'h6, 4'h4, 4'h8, 4'hA};
  // read command families
  typedef enum logic [1:0] {
    FSCS_RD_FAST,
    FSCS_RD_DIO,
    FSCS_RD_QIO
  } fscs_family_e;
endpackage

// ===== hdl/fscs_dummy_lut.sv
// dummy clock count lookup per read family
`timescale 1ns/100ps
module fscs_dummy_lut
  import fscs_pkg::*;
(
  // selection
  input  wire logic [1:0]   i_dummy_cycle_sel,
  input  wire fscs_family_e i_family,
  // result
  output logic      [3:0]   o_dummy_count
);
  // pure table lookup; the caller registers the result
  always_comb begin
    case (i_family)
      FSCS_RD_DIO: o_dummy_count = DUM_DIO[i_dummy_cycle_sel];
      FSCS_RD_QIO: o_dummy_count = DUM_QIO[i_dummy_cycle_sel];
      default:     o_dummy_count = DUM_FAST[i_dummy_cycle_sel];
    endcase
  end
endmodule

// ===== hdl/fscs_top.sv
// security register and configuration decode of the serial flash
`timescale 1ns/100ps
module fscs_top
  import fscs_pkg::*;
(
  // clock and reset
  input  wire logic         i_clock,
  input  wire logic         i_sys_rst,
  // command decoder events, same clock
  input  wire logic         i_write_status_cmd,
  input  wire logic [7:0]   i_write_status_cfg,
  input  wire logic         i_write_security_cmd,
  input  wire logic         i_protect_mode_wr,
  input  wire logic         i_erase_done,
  input  wire logic         i_erase_ok,
  input  wire logic         i_program_done,
  input  wire logic         i_program_ok,
  input  wire logic         i_erase_suspend,
  input  wire logic         i_erase_resume,
  input  wire logic         i_program_suspend,
  input  wire logic         i_program_resume,
  input  wire logic         i_otp_write_req,
  input  wire logic         i_otp_mode,
  input  wire logic         i_array_req,
  input  wire fscs_family_e i_read_family,
  // factory strap, from pins
  input  wire logic         i_factory_lock,
  // outputs
  output logic      [7:0]   o_security_flags,
  output logic      [1:0]   o_dummy_cycle_sel,
  output logic      [2:0]   o_drive_strength_sel,
  output logic      [7:0]   o_drive_level,
  output logic      [3:0]   o_dummy_count,
  output logic              o_otp_write_grant,
  output logic              o_array_grant
);
  // state
  logic       protect_mode_select, next_protect_mode_select;
  logic       erase_fail,          next_erase_fail;
  logic       program_fail,        next_program_fail;
  logic       erase_suspended_flag, next_erase_suspended_flag;
  logic       program_suspended_flag, next_program_suspended_flag;
  logic       otp_lockdown_bit,    next_otp_lockdown_bit;
  logic [1:0] dummy_cycle_sel,     next_dummy_cycle_sel;
  logic [2:0] drive_strength_sel,  next_drive_strength_sel;
  logic [7:0] drive_level,         next_drive_level;
  logic [3:0] dummy_count;         // registered lookup
  logic [3:0] lut_count;           // lookup result
  logic       fact_meta, fact_sync; // strap synchroniser

  // strap arrives from a pin: two stages before use
  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      fact_meta <= 1'b0;
      fact_sync <= 1'b0;
    end else begin
      fact_meta <= i_factory_lock;
      fact_sync <= fact_meta;
    end
  end

  // lookup of dummy count for the active read family
  fscs_dummy_lut u_lut (
    .i_dummy_cycle_sel (dummy_cycle_sel),
    .i_family          (i_read_family),
    .o_dummy_count     (lut_count)
  );

  // next state of flags and configuration
  always_comb begin
    next_protect_mode_select    = protect_mode_select;
    next_erase_fail             = erase_fail;
    next_program_fail           = program_fail;
    next_erase_suspended_flag   = erase_suspended_flag;
    next_program_suspended_flag = program_suspended_flag;
    next_otp_lockdown_bit       = otp_lockdown_bit;
    next_dummy_cycle_sel        = dummy_cycle_sel;
    next_drive_strength_sel     = drive_strength_sel;
    // fail flags only report; nothing here gates an operation
    if (i_erase_done) begin
      next_erase_fail = !i_erase_ok;
    end
    if (i_program_done) begin
      next_program_fail = !i_program_ok;
    end
    // resume clears; a suspend in the same cycle wins
    if (i_erase_resume) begin
      next_erase_suspended_flag = 1'b0;
    end
    if (i_erase_suspend) begin
      next_erase_suspended_flag = 1'b1;
    end
    if (i_program_resume) begin
      next_program_suspended_flag = 1'b0;
    end
    if (i_program_suspend) begin
      next_program_suspended_flag = 1'b1;
    end
    // lock-down is one-way: never cleared except by reset
    if (i_write_security_cmd) begin
      next_otp_lockdown_bit = 1'b1;
    end
    // protect mode select set once, sticky like an otp bit
    if (i_protect_mode_wr) begin
      next_protect_mode_select = 1'b1;
    end
    // configuration only through the status write command
    if (i_write_status_cmd) begin
      next_drive_strength_sel =
        i_write_status_cfg[CFG_DS_LSB +: 3];
      next_dummy_cycle_sel = i_write_status_cfg[CFG_DC_LSB +: 2];
    end
  end

  // drive level decode, one-hot weakest to strongest
  always_comb begin
    next_drive_level = 8'h00;
    next_drive_level[next_drive_strength_sel] = 1'b1;
  end

  // registers; volatile fields return to defaults on reset
  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      protect_mode_select    <= 1'b0;
      erase_fail             <= 1'b0;
      program_fail           <= 1'b0;
      erase_suspended_flag   <= 1'b0;
      program_suspended_flag <= 1'b0;
      otp_lockdown_bit       <= 1'b0;
      dummy_cycle_sel        <= DC_DEFAULT;
      drive_strength_sel     <= DS_DEFAULT;
      // one-hot image of the default drive code, kept in step with it
      drive_level            <= 8'h01 << DS_DEFAULT;
      dummy_count            <= DUM_FAST[DC_DEFAULT];
    end else begin
      protect_mode_select    <= next_protect_mode_select;
      erase_fail             <= next_erase_fail;
      program_fail           <= next_program_fail;
      erase_suspended_flag   <= next_erase_suspended_flag;
      program_suspended_flag <= next_program_suspended_flag;
      otp_lockdown_bit       <= next_otp_lockdown_bit;
      dummy_cycle_sel        <= next_dummy_cycle_sel;
      drive_strength_sel     <= next_drive_strength_sel;
      drive_level            <= next_drive_level;
      dummy_count            <= lut_count;
    end
  end

  // register image, reserved bit reads zero
  always_comb begin
    o_security_flags                = 8'h00;
    o_security_flags[SEC_PMODE_BIT] = protect_mode_select;
    o_security_flags[SEC_EFAIL_BIT] = erase_fail;
    o_security_flags[SEC_PFAIL_BIT] = program_fail;
    o_security_flags[SEC_ESUSP_BIT] = erase_suspended_flag;
    o_security_flags[SEC_PSUSP_BIT] = program_suspended_flag;
    o_security_flags[SEC_LOCK_BIT]  = otp_lockdown_bit;
    o_security_flags[SEC_FACT_BIT]  = fact_sync;
  end

  // grants are handshake terms, combinational
  assign o_otp_write_grant = i_otp_write_req && !otp_lockdown_bit;
  assign o_array_grant     = i_array_req && !i_otp_mode;
  assign o_dummy_cycle_sel    = dummy_cycle_sel;
  assign o_drive_strength_sel = drive_strength_sel;
  assign o_drive_level        = drive_level;
  assign o_dummy_count        = dummy_count;

  // checks
  property p_efail;
    @(posedge i_clock) disable iff (i_sys_rst)
      i_erase_done |=> (erase_fail == !$past(i_erase_ok));
  endproperty
  a_efail: assert property (p_efail) else $error("erase fail");
  property p_efail_hold;
    @(posedge i_clock) disable iff (i_sys_rst)
      !i_erase_done |=> $stable(erase_fail);
  endproperty
  a_efail_hold: assert property (p_efail_hold)
    else $error("erase fail moved");
  property p_pfail;
    @(posedge i_clock) disable iff (i_sys_rst)
      i_program_done |=> (program_fail == !$past(i_program_ok));
  endproperty
  a_pfail: assert property (p_pfail) else $error("prog fail");
  property p_esusp;
    @(posedge i_clock) disable iff (i_sys_rst)
      i_erase_suspend |=> o_security_flags[SEC_ESUSP_BIT];
  endproperty
  a_esusp: assert property (p_esusp) else $error("esusp");
  property p_psusp;
    @(posedge i_clock) disable iff (i_sys_rst)
      (i_program_resume && !i_program_suspend) |=>
        !o_security_flags[SEC_PSUSP_BIT];
  endproperty
  a_psusp: assert property (p_psusp) else $error("psusp");
  property p_lock;
    @(posedge i_clock) disable iff (i_sys_rst)
      otp_lockdown_bit |-> !o_otp_write_grant ##1 otp_lockdown_bit;
  endproperty
  a_lock: assert property (p_lock) else $error("lock");
  property p_array;
    @(posedge i_clock) disable iff (i_sys_rst)
      i_otp_mode |-> !o_array_grant;
  endproperty
  a_array: assert property (p_array) else $error("array");
  property p_ds;
    @(posedge i_clock) disable iff (i_sys_rst)
      !i_write_status_cmd |=> $stable(drive_strength_sel);
  endproperty
  a_ds: assert property (p_ds) else $error("drive");
  property p_rsvd;
    @(posedge i_clock) disable iff (i_sys_rst)
      !o_security_flags[SEC_RSVD_BIT];
  endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved");
endmodule

// ===== test/fscs_host.sv
// host controller model that issues command events to the flash block
`timescale 1ns/100ps
module fscs_host (
  // clock
  input  wire logic       i_clock,
  // command events, one cycle each
  output logic            o_write_status_cmd,
  output logic [7:0]      o_write_status_cfg,
  output logic            o_write_security_cmd,
  output logic            o_protect_mode_wr,
  output logic            o_erase_done,
  output logic            o_erase_ok,
  output logic            o_program_done,
  output logic            o_program_ok,
  output logic            o_erase_suspend,
  output logic            o_erase_resume,
  output logic            o_program_suspend,
  output logic            o_program_resume
);
  logic [8:0] ev;   // strobe bits, see send below
  logic [7:0] cfg;  // status write payload
  logic       ok;   // operation outcome, shared by erase and program
  initial begin
    ev  = '0;
    cfg = 8'h00;
    ok  = 1'b0;
  end
  // drive strength and dummy code only move through the status write
  assign o_write_status_cmd   = ev[0];
  assign o_write_status_cfg   = cfg;
  assign o_write_security_cmd = ev[1];
  assign o_protect_mode_wr    = ev[2];
  assign o_erase_done         = ev[3];
  assign o_program_done       = ev[4];
  assign o_erase_suspend      = ev[5];
  assign o_erase_resume       = ev[6];
  assign o_program_suspend    = ev[7];
  assign o_program_resume     = ev[8];
  assign o_erase_ok           = ok;
  assign o_program_ok         = ok;
  // one event cycle; returns just after the edge that took it, so the
  // registered answer is already visible to the caller
  task automatic send(input logic [8:0] e, input logic [7:0] c,
                      input logic k);
    @(posedge i_clock);
    #1;
    ev  = e;
    cfg = c;
    ok  = k;
    @(posedge i_clock);
    #1;
    ev  = '0;
    cfg = ~c;  // stale payload is not left on the lines
    ok  = ~k;
  endtask
endmodule

// ===== test/fscs_top_test.sv
// self-checking bench for the flash security and configuration block
`timescale 1ns/100ps
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin \
  error_cnt++; $display("[FAIL] %0t got %h exp %h", $time, a, b); end end
module fscs_top_test;
  import fscs_pkg::*;
  logic i_clock, i_sys_rst, otp_req, otp_mode, arr_req, strap;
  fscs_family_e fam;
  logic [7:0] flags, level;
  logic [1:0] dsel;
  logic [2:0] drv;
  logic [3:0] dcnt;
  logic otp_gnt, arr_gnt;
  logic cmd_st, cmd_sec, cmd_pm, e_dn, e_ok, p_dn, p_ok;
  logic e_su, e_re, p_su, p_re;
  logic [7:0] cfg;
  int error_cnt = 0;
  int samples_checked = 0;
  // expected dummy counts: fast, dual io, quad io, codes 0 to 3
  logic [3:0] dum [12] = '{4'h8, 4'h6, 4'h8, 4'hA, 4'h4, 4'h6, 4'h8,
                           4'hA, 4'h6, 4'h4, 4'h8, 4'hA};
  fscs_host host (.i_clock(i_clock), .o_write_status_cmd(cmd_st),
    .o_write_status_cfg(cfg), .o_write_security_cmd(cmd_sec),
    .o_protect_mode_wr(cmd_pm), .o_erase_done(e_dn), .o_erase_ok(e_ok),
    .o_program_done(p_dn), .o_program_ok(p_ok), .o_erase_suspend(e_su),
    .o_erase_resume(e_re), .o_program_suspend(p_su),
    .o_program_resume(p_re));
  fscs_top dut (.i_clock(i_clock), .i_sys_rst(i_sys_rst),
    .i_write_status_cmd(cmd_st), .i_write_status_cfg(cfg),
    .i_write_security_cmd(cmd_sec), .i_protect_mode_wr(cmd_pm),
    .i_erase_done(e_dn), .i_erase_ok(e_ok), .i_program_done(p_dn),
    .i_program_ok(p_ok), .i_erase_suspend(e_su), .i_erase_resume(e_re),
    .i_program_suspend(p_su), .i_program_resume(p_re),
    .i_otp_write_req(otp_req), .i_otp_mode(otp_mode),
    .i_array_req(arr_req), .i_read_family(fam), .i_factory_lock(strap),
    .o_security_flags(flags), .o_dummy_cycle_sel(dsel),
    .o_drive_strength_sel(drv), .o_drive_level(level),
    .o_dummy_count(dcnt), .o_otp_write_grant(otp_gnt),
    .o_array_grant(arr_gnt));
  // 50 MHz clock
  initial begin
    i_clock = 1'b0;
    forever #10 i_clock = ~i_clock;
  end
  // sync reset held two cycles, then the defaults are checked
  task automatic do_reset();
    i_sys_rst = 1'b1;
    repeat (2) @(posedge i_clock);
    #1;
    i_sys_rst = 1'b0;
    `CHK(flags, 8'h00)
    `CHK(dsel, 2'h0)
    `CHK(drv, 3'h7)
    `CHK(level, 8'h80)
    `CHK(dcnt, 4'h8)
  endtask
  // every code on every read family, drive code swept alongside
  task automatic t_config();
    for (int f = 0; f < 3; f++) begin
      fam = fscs_family_e'(f);
      for (int i = 0; i < 8; i++) begin
        host.send(9'h001, {i[1:0], 3'h0, i[2:0]}, 1'b0);
        `CHK(level, 8'h01 << i)
        `CHK(dsel, i[1:0])
        `CHK(drv, i[2:0])
        @(posedge i_clock);
        #1;
        `CHK(dcnt, dum[f * 4 + i % 4])
      end
    end
  endtask
  // fail flags set and clear, array access keeps going meanwhile
  task automatic t_fail(input logic [8:0] ev, input int b);
    arr_req = 1'b1;
    host.send(ev, 8'h00, 1'b0);
    `CHK(flags[b], 1'b1)
    `CHK(arr_gnt, 1'b1)
    host.send(ev, 8'h00, 1'b1);
    `CHK(flags[b], 1'b0)
  endtask
  // suspend then resume, then both together where suspend wins
  task automatic t_susp(input logic [8:0] su, input logic [8:0] re,
                        input int b);
    host.send(su, 8'h00, 1'b0);
    `CHK(flags[b], 1'b1)
    host.send(re, 8'h00, 1'b0);
    `CHK(flags[b], 1'b0)
    host.send(su | re, 8'h00, 1'b0);
    `CHK(flags[b], 1'b1)
    host.send(re, 8'h00, 1'b0);
  endtask
  // strap, lock-down, protect mode and otp mode gating
  task automatic t_lock();
    // non-default drive code, so a later security write that disturbs
    // it cannot hide behind the reset value
    host.send(9'h001, 8'h02, 1'b0);
    strap = 1'b1;
    repeat (2) @(posedge i_clock);
    #1;
    `CHK(flags[0], 1'b1)
    otp_req = 1'b1;
    // grant is combinational: let it settle before looking
    #1;
    `CHK(otp_gnt, 1'b1)
    host.send(9'h002, 8'h00, 1'b0);
    `CHK(otp_gnt, 1'b0)
    host.send(9'h004, 8'h00, 1'b0);
    host.send(9'h002, 8'h00, 1'b0);
    `CHK(flags, 8'h83)
    `CHK(drv, 3'h2)
    otp_mode = 1'b1;
    #1;
    `CHK(arr_gnt, 1'b0)
    // inputs only move just after an edge
    @(posedge i_clock);
    #1;
    otp_mode = 1'b0;
    #1;
    `CHK(arr_gnt, 1'b1)
    @(posedge i_clock);
    #1;
  endtask
  task automatic test_done();
    $display("checks %0d errors %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // watchdog, well past the roughly 112 cycles the run needs
  initial begin
    #400000;
    error_cnt++;
    test_done();
  end
  initial begin
    {otp_req, otp_mode, arr_req, strap} = 4'h0;
    fam = FSCS_RD_FAST;
    do_reset();
    t_config();
    t_fail(9'h008, SEC_EFAIL_BIT);
    t_fail(9'h010, SEC_PFAIL_BIT);
    t_susp(9'h020, 9'h040, SEC_ESUSP_BIT);
    t_susp(9'h080, 9'h100, SEC_PSUSP_BIT);
    t_lock();
    strap = 1'b0;
    do_reset();
    test_done();
  end
endmodule
